// File: rtl/iacs_params.svh
// Constants of the incremental converter sequencer.
`ifndef IACS_PARAMS_SVH
`define IACS_PARAMS_SVH
`define IACS_OSC_HZ 4000000
`define IACS_CLK_HZ 125000000
`define IACS_OSC_DIV ((`IACS_CLK_HZ) / (`IACS_OSC_HZ))
`define IACS_FS_BASE_DIV 64
`define IACS_OSR_LOG_BASE 3
`define IACS_RES_MAX 16
`define IACS_RES_MIN 6
`define IACS_POS_MAX 16'h7fff
`define IACS_NEG_MAX 16'h8000
`define IACS_RESULT_RST 16'h0000
`endif

// File: rtl/iacs_pkg.sv
// Types shared by the incremental converter sequencer.
package iacs_pkg;
	typedef struct packed {
		logic [1:0] rate_select;
		logic [2:0] ratio_select;
		logic [1:0] elementary_count_select;
		logic continuous;
	} iacs_cfg_t;
	typedef enum logic [1:0] {
		IACS_IDLE = 2'b00,
		IACS_INTEG = 2'b01,
		IACS_QUANT = 2'b10
	} iacs_state_t;
endpackage

// File: rtl/iacs_sequencer.sv
// Conversion sequencer of an incremental oversampling converter.
`timescale 1ns/1ns
`include "iacs_params.svh"

// Overview of operation
// - Two-bit rate select picks 62.5 to 500 kHz.
// - Oversampling clock divided from internal 4 MHz.
// - Ratio equals two to three plus field.
// - Elementary conversions equal two to count field.
// - Resolution is twice log2 ratio plus log2 count.
// - Effective resolution capped at sixteen bits.
// - Conversion lasts count times ratio-plus-one, plus one.
// - Start or default trigger begins new conversion.
// - Alternate offset polarity and average elementary results.
// - Continuous mode restarts; on-request waits for start.
// - Result is saturated two's complement word.
module iacs_sequencer #(
	parameter int SAMPLE_W = 18
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire iacs_pkg::iacs_cfg_t i_cfg,
	input wire logic i_start,
	input wire logic i_default_trigger,
	input wire logic signed [SAMPLE_W-1:0] i_elem_sample,
	output logic o_osc_tick,
	output logic o_fs_tick,
	output logic o_busy,
	output logic o_offset_polarity,
	output logic o_integrate,
	output logic o_elem_done,
	output logic [4:0] o_resolution,
	output logic [15:0] o_conversion_result,
	output logic o_conv_done
);
	import iacs_pkg::*;

	// -------------------------------------------------------------
	// Functions
	// -------------------------------------------------------------

	// Resolution in bits from ratio and count codes.
	function automatic logic [4:0] res_of(input logic [2:0] r, input logic [1:0] n);
		logic [4:0] t;
		t = 5'((5'(r) + 5'(`IACS_OSR_LOG_BASE)) * 5'd2 + 5'(n));
		res_of = (t > 5'(`IACS_RES_MAX)) ? 5'(`IACS_RES_MAX) : t;
	endfunction

	// Saturate a wide signed value to sixteen bits.
	function automatic logic [15:0] sat16(input logic signed [SAMPLE_W+3:0] v);
		if (v > $signed((SAMPLE_W+4)'(`IACS_POS_MAX)))
			sat16 = `IACS_POS_MAX;
		else if (v < -$signed((SAMPLE_W+4)'(`IACS_NEG_MAX)))
			sat16 = `IACS_NEG_MAX;
		else
			sat16 = v[15:0];
	endfunction

	// -------------------------------------------------------------
	// Clock dividers
	// -------------------------------------------------------------

	logic [5:0] osc_cnt_r, osc_cnt_nxt;
	logic [9:0] fs_cnt_r, fs_cnt_nxt;
	logic osc_tick, fs_tick;
	logic [9:0] fs_div;

	// Internal 4 MHz tick, then oversampling tick divided from it.
	always_comb begin
		osc_tick = (osc_cnt_r == 6'(`IACS_OSC_DIV - 1));
		osc_cnt_nxt = osc_tick ? 6'h00 : osc_cnt_r + 6'h01;
		fs_div = 10'(`IACS_FS_BASE_DIV) >> i_cfg.rate_select;
		fs_tick = osc_tick && (fs_cnt_r >= fs_div - 10'h001); // A faster rate must not strand the count.
		fs_cnt_nxt = fs_cnt_r;
		if (osc_tick)
			fs_cnt_nxt = fs_tick ? 10'h000 : fs_cnt_r + 10'h001;
	end

	// Register the divider counts.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			osc_cnt_r <= 6'h00;
			fs_cnt_r <= 10'h000;
		end else begin
			osc_cnt_r <= osc_cnt_nxt;
			fs_cnt_r <= fs_cnt_nxt;
		end
	end

	// -------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------

	iacs_state_t state_r, state_nxt;
	iacs_cfg_t cfg_r, cfg_nxt;
	logic [10:0] per_cnt_r, per_cnt_nxt;
	logic [3:0] elem_cnt_r, elem_cnt_nxt;
	logic pol_r, pol_nxt;
	logic pend_r, pend_nxt;
	logic signed [SAMPLE_W+3:0] acc_r, acc_nxt;
	logic [15:0] result_r, result_nxt;
	logic done_r, done_nxt;
	logic elem_done_r, elem_done_nxt;
	logic [4:0] res_r, res_nxt;
	logic [10:0] osr_len;
	logic [3:0] nel_len;
	logic trig;
	logic signed [SAMPLE_W+3:0] term;

	// Next state of the conversion sequence.
	always_comb begin
		trig = i_start | i_default_trigger;
		osr_len = 11'd1 << (4'(cfg_r.ratio_select) + 4'(`IACS_OSR_LOG_BASE)); // Four bits reach ten.
		nel_len = 4'd1 << cfg_r.elementary_count_select;
		term = pol_r ? -(SAMPLE_W+4)'(i_elem_sample) : (SAMPLE_W+4)'(i_elem_sample);
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		per_cnt_nxt = per_cnt_r;
		elem_cnt_nxt = elem_cnt_r;
		pol_nxt = pol_r;
		pend_nxt = pend_r | trig;
		acc_nxt = acc_r;
		result_nxt = result_r;
		done_nxt = 1'b0;
		elem_done_nxt = 1'b0;
		unique case (state_r)
			IACS_IDLE: begin
				if (fs_tick && pend_r) begin
					state_nxt = IACS_INTEG;
					cfg_nxt = i_cfg;
					per_cnt_nxt = 11'h000;
					elem_cnt_nxt = 4'h0;
					pol_nxt = 1'b0;
					acc_nxt = '0;
					pend_nxt = trig;
				end
			end
			IACS_INTEG: begin
				// Each elementary conversion spans ratio plus one periods.
				if (fs_tick) begin
					if (per_cnt_r == osr_len) begin
						per_cnt_nxt = 11'h000;
						acc_nxt = acc_r + term;
						pol_nxt = ~pol_r;
						elem_done_nxt = 1'b1;
						if (elem_cnt_r == nel_len - 4'h1)
							state_nxt = IACS_QUANT;
						else
							elem_cnt_nxt = elem_cnt_r + 4'h1;
					end else begin
						per_cnt_nxt = per_cnt_r + 11'h001;
					end
				end
			end
			IACS_QUANT: begin
				// One final quantization period, then the averaged result.
				if (fs_tick) begin
					result_nxt = sat16(acc_r >>> cfg_r.elementary_count_select);
					done_nxt = 1'b1;
					if (cfg_r.continuous) begin
						state_nxt = IACS_INTEG;
						cfg_nxt = i_cfg;
						per_cnt_nxt = 11'h000;
						elem_cnt_nxt = 4'h0;
						pol_nxt = 1'b0;
						acc_nxt = '0;
						pend_nxt = trig;
					end else begin
						state_nxt = IACS_IDLE;
					end
				end
			end
			default: state_nxt = IACS_IDLE;
		endcase
		res_nxt = res_of(cfg_nxt.ratio_select, cfg_nxt.elementary_count_select);
	end

	// Register the sequencer state and the held result.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_r <= IACS_IDLE;
			cfg_r <= '0;
			per_cnt_r <= 11'h000;
			elem_cnt_r <= 4'h0;
			pol_r <= 1'b0;
			pend_r <= 1'b0;
			acc_r <= '0;
			result_r <= `IACS_RESULT_RST;
			done_r <= 1'b0;
			elem_done_r <= 1'b0;
			res_r <= 5'(`IACS_RES_MIN);
		end else begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
			per_cnt_r <= per_cnt_nxt;
			elem_cnt_r <= elem_cnt_nxt;
			pol_r <= pol_nxt;
			pend_r <= pend_nxt;
			acc_r <= acc_nxt;
			result_r <= result_nxt;
			done_r <= done_nxt;
			elem_done_r <= elem_done_nxt;
			res_r <= res_nxt;
		end
	end

	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------

	// Status and timing outputs.
	assign o_osc_tick = osc_tick;
	assign o_fs_tick = fs_tick;
	assign o_busy = (state_r != IACS_IDLE);
	assign o_offset_polarity = pol_r;
	assign o_integrate = (state_r == IACS_INTEG);
	assign o_elem_done = elem_done_r;
	assign o_resolution = res_r;
	assign o_conversion_result = result_r;
	assign o_conv_done = done_r;
endmodule

// File: verif/iacs_monitor.sv
// Port checker of the incremental converter sequencer.
`timescale 1ns/1ns
module iacs_monitor (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic o_osc_tick,
	input wire logic o_fs_tick,
	input wire logic o_busy,
	input wire logic o_integrate,
	input wire logic o_offset_polarity,
	input wire logic o_elem_done,
	input wire logic [4:0] o_resolution,
	input wire logic [15:0] o_conversion_result,
	input wire logic o_conv_done
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	a_osc_period: assert property (o_osc_tick |-> ##31 o_osc_tick) else $error("osc tick spacing");
	a_fs_on_osc: assert property (o_fs_tick |-> o_osc_tick) else $error("fs tick off osc");
	a_done_single: assert property (o_conv_done |=> !o_conv_done) else $error("done too long");
	a_done_busy: assert property (o_conv_done |-> $past(o_busy)) else $error("done while idle");
	a_done_after_fs: assert property (o_conv_done |-> $past(o_fs_tick)) else $error("done off tick");
	a_res_cap: assert property (o_resolution <= 5'h10) else $error("resolution above cap");
	a_res_min: assert property (o_conv_done |-> o_resolution >= 5'h06) else $error("resolution low");
	a_integ_on_tick: assert property ($rose(o_integrate) |-> $past(o_fs_tick))
		else $error("integration off tick");
	a_pol_toggle: assert property (o_elem_done |-> (o_offset_polarity != $past(o_offset_polarity)))
		else $error("polarity not alternated");
	a_elem_on_tick: assert property (o_elem_done |-> ($past(o_fs_tick) && $past(o_integrate)))
		else $error("elementary end off tick");
	a_result_hold: assert property (!o_conv_done |-> $stable(o_conversion_result)) else $error("result moved");
	// Main scenarios reached by the bench.
	c_done: cover property (o_conv_done);
	c_quant: cover property ($fell(o_integrate) && o_busy);
	c_again: cover property (o_conv_done ##1 o_busy);
endmodule

// File: verif/test_incremental_adc_conversion_sequencer.sv
// Self-checking bench of the incremental converter sequencer.
`timescale 1ns/1ns
module test_incremental_adc_conversion_sequencer;
	import iacs_pkg::*;
	logic i_ref_clk = 0, i_rst = 1, i_start = 0, i_default_trigger = 0;
	logic o_osc_tick, o_fs_tick, o_busy, o_offset_polarity, o_integrate, o_elem_done, o_conv_done;
	logic [4:0] o_resolution;
	logic [15:0] o_conversion_result;
	logic signed [17:0] i_elem_sample = 18'h0;
	iacs_cfg_t i_cfg = '0;
	int fail_count = 0, comparisons = 0;
	int elem_seen = 0;
	// Sequencer under test.
	iacs_sequencer iacs_sequencer_inst (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_cfg(i_cfg),
		.i_start(i_start),
		.i_default_trigger(i_default_trigger),
		.i_elem_sample(i_elem_sample),
		.o_osc_tick(o_osc_tick),
		.o_fs_tick(o_fs_tick),
		.o_busy(o_busy),
		.o_offset_polarity(o_offset_polarity),
		.o_integrate(o_integrate),
		.o_elem_done(o_elem_done),
		.o_resolution(o_resolution),
		.o_conversion_result(o_conversion_result),
		.o_conv_done(o_conv_done)
	);
	// Clock of 8 ns period.
	always #4 i_ref_clk = ~i_ref_clk;
	// Compares a seen value with the expected one.
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task wrap_up();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Waits up to n cycles for a done pulse, counting fs ticks while busy and elementary ends.
	task wait_done(input int n, output int f);
		int k;
		k = 0;
		f = 0;
		elem_seen = 0;
		while (!o_conv_done && k < n) begin
			@(negedge i_ref_clk);
			k++;
			f += int'(o_busy && o_fs_tick);
			if (o_elem_done) begin
				elem_seen++;
				chk(o_offset_polarity, elem_seen % 2);
			end
		end
		if (k >= n) begin
			chk(1, 0);
			wrap_up();
		end
	endtask
	// One conversion: period count, result and resolution.
	task run_conv(input [2:0] r, input [1:0] c, input [17:0] s, input [15:0] res, input d);
		int f, e;
		e = (2 * (r + 3) + c > 16) ? 16 : 2 * (r + 3) + c;
		@(negedge i_ref_clk);
		i_cfg = '{2'h3, r, c, 1'b0};
		i_elem_sample = s;
		if (d) i_default_trigger = 1;
		else i_start = 1;
		@(negedge i_ref_clk);
		i_start = 0;
		i_default_trigger = 0;
		wait_done(40000, f);
		chk(f, (1 << c) * ((8 << r) + 1) + 1);
		chk(elem_seen, 1 << c);
		chk(o_conversion_result, res);
		chk(o_resolution, e);
		@(negedge i_ref_clk);
		chk(o_busy, 0);
	endtask
	// Spacing of fs ticks for every rate code.
	task t_rate();
		int k;
		for (int rt = 0; rt < 4; rt++) begin
			i_cfg.rate_select = rt[1:0];
			k = 0;
			while (!o_fs_tick && k < 3000) begin
				@(negedge i_ref_clk);
				k++;
			end
			if (k >= 3000) begin
				chk(1, 0);
				wrap_up();
			end
			k = 0;
			do begin
				@(negedge i_ref_clk);
				k++;
			end while (!o_fs_tick && k < 3000);
			chk(k, 31 * (64 >> rt));
		end
	endtask
	// Cap on resolution at the largest settings, then reset in mid-run.
	task t_cap();
		i_cfg = '{2'h3, 3'h7, 2'h3, 1'b0};
		i_start = 1;
		repeat (300) @(negedge i_ref_clk);
		i_start = 0;
		chk(o_resolution, 16);
		i_rst = 1;
		repeat (3) @(negedge i_ref_clk);
		i_rst = 0;
		chk(o_busy, 0);
	endtask
	// Continuous mode restarts with no new trigger.
	task t_cont();
		int f;
		i_cfg = '{2'h3, 3'h0, 2'h0, 1'b1};
		i_start = 1;
		@(negedge i_ref_clk);
		i_start = 0;
		wait_done(3000, f);
		@(negedge i_ref_clk);
		wait_done(3000, f);
		chk(f, 10);
		i_cfg.continuous = 0;
		@(negedge i_ref_clk);
		wait_done(3000, f);
		@(negedge i_ref_clk);
		chk(o_busy, 1);
		wait_done(3000, f);
		chk(f, 10);
		@(negedge i_ref_clk);
		chk(o_busy, 0);
	endtask
	// Scenario order, then the verdict.
	initial begin
		repeat (3) @(negedge i_ref_clk);
		i_rst = 0;
		t_rate();
		run_conv(3'h0, 2'h0, 18'h00123, 16'h0123, 0);
		run_conv(3'h0, 2'h1, 18'h00123, 16'h0000, 1);
		run_conv(3'h1, 2'h1, 18'h01000, 16'h0000, 0);
		run_conv(3'h0, 2'h0, 18'h1ffff, 16'h7fff, 0);
		run_conv(3'h0, 2'h0, 18'h20000, 16'h8000, 1);
		t_cap();
		t_cont();
		wrap_up();
	end
endmodule
bind iacs_sequencer iacs_monitor iacs_monitor_inst (.i_ref_clk, .i_rst, .o_osc_tick, .o_fs_tick, .o_busy,
	.o_integrate, .o_offset_polarity, .o_elem_done, .o_resolution, .o_conversion_result, .o_conv_done);
